// >>> rtl/gpp_port.sv
// Eight-pin general purpose port with AHB-Lite register slave.
`timescale 1ns/1ps
module gpp_port (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pullup,
    output logic [7:0] pin_event,
    input wire logic [7:0] periph_drive,
    input wire logic [7:0] periph_drive_en,
    output logic port_irq
);
    gpp_pkg::gpp_state_t s;
    gpp_pkg::gpp_state_t next_s;

    function automatic logic [2:0] sense_of(input logic [7:0] ctl);
        return ctl[gpp_pkg::POS_SENSE +: 3];
    endfunction

    // Maps an alias offset onto the regular register offset it mirrors.
    function automatic logic [7:0] unalias(input logic [7:0] a);
        logic [7:0] r;
        r = a;
        if (a[7:2] == gpp_pkg::OFF_ALIAS[7:2]) begin
            case (a[1:0])
                gpp_pkg::ALIAS_DIR[1:0]: r = gpp_pkg::OFF_DIR;
                gpp_pkg::ALIAS_OUT[1:0]: r = gpp_pkg::OFF_OUT;
                gpp_pkg::ALIAS_IN[1:0]: r = gpp_pkg::OFF_IN;
                default: r = gpp_pkg::OFF_FLAGS;
            endcase
        end
        return r;
    endfunction

    // The read mux is fed with the next state, so a read right behind a write already sees the new value.
    function automatic logic [7:0] read_reg(input gpp_pkg::gpp_state_t st, input logic [7:0] a);
        logic [7:0] r;
        r = gpp_pkg::REG8_RST;
        if (a[7:3] == gpp_pkg::OFF_PIN_CTRL[7:3]) begin
            r = st.pin_control[a[2:0]];
        end else begin
            case (a)
                gpp_pkg::OFF_DIR: r = st.drive_en_mask;
                gpp_pkg::OFF_OUT: r = st.drive_value;
                gpp_pkg::OFF_IN: r = st.sampled_level;
                gpp_pkg::OFF_FLAGS: r = st.pin_event_flags;
                gpp_pkg::OFF_OVR_EN: r = st.ovr_en;
                default: r = gpp_pkg::REG8_RST;
            endcase
        end
        return r;
    endfunction

    logic [7:0] flip;
    logic [7:0] buf_on;
    logic [7:0] level;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] det;
    logic [7:0] fire;
    logic wr;

    always_comb begin
        for (int n = 0; n < gpp_pkg::PINS; n++) begin
            flip[n] = s.pin_control[n][gpp_pkg::POS_FLIP];
            buf_on[n] = sense_of(s.pin_control[n]) != gpp_pkg::SENSE_OFF;
        end
    end

    // Event level is the raw pin seen through the inverter, gated by the buffer.
    assign level = (pin_in ^ flip) & buf_on;
    assign wd = hwdata[7:0];
    assign wr = s.req.valid && s.req.write;
    assign ra = unalias(s.req.addr);

    always_comb begin
        next_s = s;
        next_s.req.valid = hsel && hready && (htrans == gpp_pkg::HTRANS_NONSEQ);
        next_s.req.write = hwrite;
        next_s.req.addr = haddr[9:2];

        if (wr) begin
            if (ra[7:3] == gpp_pkg::OFF_PIN_CTRL[7:3]) begin
                next_s.pin_control[ra[2:0]] = wd & gpp_pkg::PIN_CTRL_MASK;
            end else begin
                case (ra)
                    gpp_pkg::OFF_DIR: next_s.drive_en_mask = wd;
                    gpp_pkg::OFF_DIR_SET: next_s.drive_en_mask = s.drive_en_mask | wd;
                    gpp_pkg::OFF_DIR_CLR: next_s.drive_en_mask = s.drive_en_mask & ~wd;
                    gpp_pkg::OFF_DIR_TGL: next_s.drive_en_mask = s.drive_en_mask ^ wd;
                    gpp_pkg::OFF_OUT: next_s.drive_value = wd;
                    gpp_pkg::OFF_OUT_SET: next_s.drive_value = s.drive_value | wd;
                    gpp_pkg::OFF_OUT_CLR: next_s.drive_value = s.drive_value & ~wd;
                    gpp_pkg::OFF_OUT_TGL: next_s.drive_value = s.drive_value ^ wd;
                    gpp_pkg::OFF_IN: next_s.drive_value = s.drive_value ^ wd;
                    gpp_pkg::OFF_OVR_EN: next_s.ovr_en = wd;
                    default: next_s.drive_en_mask = s.drive_en_mask;
                endcase
            end
        end

        det = 8'h00;
        fire = 8'h00;
        for (int n = 0; n < gpp_pkg::PINS; n++) begin
            // Synchroniser halts while the buffer is off, so the input bit freezes.
            if (buf_on[n]) begin
                next_s.sync1[n] = level[n];
                next_s.sampled_level[n] = s.sync1[n];
            end
            next_s.prev_level[n] = s.sampled_level[n];
            case (sense_of(s.pin_control[n]))
                gpp_pkg::SENSE_BOTH: det[n] = s.sampled_level[n] ^ s.prev_level[n];
                gpp_pkg::SENSE_RISE: det[n] = s.sampled_level[n] & ~s.prev_level[n];
                gpp_pkg::SENSE_FALL: det[n] = ~s.sampled_level[n] & s.prev_level[n];
                gpp_pkg::SENSE_LOW: det[n] = ~s.sampled_level[n];
                // Pending events survive the off state and fire on re-enable.
                gpp_pkg::SENSE_OFF: det[n] = 1'b0;
                default: det[n] = 1'b0;
            endcase
            if (sense_of(s.pin_control[n]) == gpp_pkg::SENSE_OFF) begin
                next_s.pending[n] = s.pending[n];
            end else if (s.dead[n] != 2'h0) begin
                next_s.dead[n] = s.dead[n] - 2'h1;
                next_s.pending[n] = s.pending[n] | det[n];
            end else if (det[n] || s.pending[n]) begin
                next_s.pin_event_flags[n] = 1'b1;
                fire[n] = 1'b1;
                next_s.pending[n] = 1'b0;
                next_s.dead[n] = gpp_pkg::DEAD_CYCLES - 2'h1;
            end
            // A sense rewrite between edges drops an event held pending by the dead time; the synchroniser keeps running.
            if (wr && ra == gpp_pkg::OFF_PIN_CTRL + 8'(n) && wd[2:0] != gpp_pkg::SENSE_OFF
                && sense_of(s.pin_control[n]) != gpp_pkg::SENSE_OFF) begin
                next_s.pending[n] = 1'b0;
            end
            // Clear by writing one; a same-cycle set wins.
            if (wr && ra == gpp_pkg::OFF_FLAGS && wd[n] && !fire[n]) begin
                next_s.pin_event_flags[n] = 1'b0;
            end
        end

        for (int n = 0; n < gpp_pkg::PINS; n++) begin
            next_s.pad.drive_en[n] = s.ovr_en[n] ? periph_drive_en[n] : s.drive_en_mask[n];
            next_s.pad.drive[n] = (s.ovr_en[n] ? periph_drive[n] : s.drive_value[n]) ^ flip[n];
            next_s.pad.pull[n] = s.pin_control[n][gpp_pkg::POS_PULL] & ~next_s.pad.drive_en[n];
        end
        next_s.pad.sense_level = level;
        next_s.irq = |next_s.pin_event_flags;
        // Data phase follows the address phase; the word must stand before the edge that ends it.
        next_s.hrdata = {24'h000000, read_reg(next_s, unalias(haddr[9:2]))};
    end

    // The wake path is not asynchronous: the event level output is registered, and flags need the clock too.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign pin_out = s.pad.drive;
    assign pin_oe = s.pad.drive_en;
    assign pin_pullup = s.pad.pull;
    assign pin_event = s.pad.sense_level;
    assign port_irq = s.irq;
endmodule

// >>> rtl/gpp_pkg.sv
// Package with register map, field layout and shared types of the pin port.
package gpp_pkg;
    localparam int PINS = 8;
    localparam logic [7:0] OFF_DIR = 8'h00;
    localparam logic [7:0] OFF_DIR_SET = 8'h01;
    localparam logic [7:0] OFF_DIR_CLR = 8'h02;
    localparam logic [7:0] OFF_DIR_TGL = 8'h03;
    localparam logic [7:0] OFF_OUT = 8'h04;
    localparam logic [7:0] OFF_OUT_SET = 8'h05;
    localparam logic [7:0] OFF_OUT_CLR = 8'h06;
    localparam logic [7:0] OFF_OUT_TGL = 8'h07;
    localparam logic [7:0] OFF_IN = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h09;
    localparam logic [7:0] OFF_PIN_CTRL = 8'h10;
    localparam logic [7:0] OFF_OVR_EN = 8'h18;
    localparam logic [7:0] OFF_ALIAS = 8'h20;
    localparam logic [7:0] ALIAS_DIR = 8'h00;
    localparam logic [7:0] ALIAS_OUT = 8'h01;
    localparam logic [7:0] ALIAS_IN = 8'h02;
    localparam logic [7:0] ALIAS_FLAGS = 8'h03;
    localparam int POS_FLIP = 7;
    localparam int POS_PULL = 3;
    localparam int POS_SENSE = 0;
    localparam logic [7:0] PIN_CTRL_RST = 8'h00;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [7:0] PIN_CTRL_MASK = 8'h8F;
    localparam logic [1:0] DEAD_CYCLES = 2'h3;
    localparam logic [2:0] SENSE_INTDISABLE = 3'h0;
    localparam logic [2:0] SENSE_BOTH = 3'h1;
    localparam logic [2:0] SENSE_RISE = 3'h2;
    localparam logic [2:0] SENSE_FALL = 3'h3;
    localparam logic [2:0] SENSE_OFF = 3'h4;
    localparam logic [2:0] SENSE_LOW = 3'h5;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } gpp_req_t;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] drive_en;
        logic [7:0] pull;
        logic [7:0] sense_level;
    } gpp_pad_t;

    typedef struct packed {
        logic [7:0] drive_en_mask;
        logic [7:0] drive_value;
        logic [7:0] pin_event_flags;
        logic [7:0] ovr_en;
        logic [7:0][7:0] pin_control;
        logic [7:0] sync1;
        logic [7:0] sampled_level;
        logic [7:0] prev_level;
        logic [7:0][1:0] dead;
        logic [7:0] pending;
        gpp_req_t req;
        logic [31:0] hrdata;
        gpp_pad_t pad;
        logic irq;
    } gpp_state_t;
endpackage

// >>> tb/gpp_port_sva.sv
// Concurrent checks of the pin port at its bus and pad ports.
`timescale 1ns/1ps
module gpp_port_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] pin_event,
    input wire logic [7:0] periph_drive,
    input wire logic [7:0] periph_drive_en,
    input wire logic port_irq
);
    logic wr;
    assign wr = hsel && hready && htrans == gpp_pkg::HTRANS_NONSEQ && hwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Pad driver outputs only move as a late effect of a bus write or of an override input change.
    sequence s_cause;
        $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4)
            || $past({periph_drive, periph_drive_en}) != $past({periph_drive, periph_drive_en}, 3);
    endsequence
    sequence s_pin_moved;
        $past(pin_in) != $past(pin_in, 2);
    endsequence
    a_reset_drivers_off: assert property ($past(arst_n) == 1'b0 |-> pin_oe == 8'h00 && port_irq == 1'b0)
        else $error("driver or request on after reset");
    a_no_wait_okay: assert property ($past(arst_n) == 1'b1 |-> hreadyout == 1'b1 && hresp == 1'b0)
        else $error("slave stalled or failed");
    a_read_upper_zero: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data above eight pins");
    a_dir_by_write: assert property ($changed(pin_oe) |-> s_cause)
        else $error("driver enable moved alone");
    a_level_by_write: assert property ($changed(pin_out) |-> s_cause)
        else $error("driven level moved alone");
    a_pull_off_out: assert property ((pin_pullup & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    a_irq_held: assert property ($fell(port_irq) |-> s_cause)
        else $error("request dropped without clear");
    a_event_from_pin: assert property ($changed(pin_event) |-> s_pin_moved or s_cause)
        else $error("event moved without pin change");
endmodule
bind gpp_port gpp_port_sva u_sva (.clk, .arst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
    .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_event, .periph_drive, .periph_drive_en, .port_irq);

// >>> tb/gpp_pad_model.sv
// Pad model that resolves each pin from the port driver, an outside source and the pull-up.
`timescale 1ns/1ps
module gpp_pad_model (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_lvl,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    // A floating pin flips every cycle, so a stale level never passes for a real one.
    logic [7:0] wander = 8'h00;
    always @(posedge clk)
        wander <= ~wander;
    always_comb
        for (int i = 0; i < 8; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_lvl[i] : pin_pullup[i] | wander[i];
endmodule

// >>> tb/tb.sv
// Self-checking bench of the pin port.
`timescale 1ns/1ps
module tb;
    logic clk, arst_n, hsel, hwrite, hreadyout, hresp, port_irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, pin_event, periph_drive, periph_drive_en;
    logic [7:0] ext_lvl, ext_en, dir, out, d, op, f;
    int n_errors, checks_done, seed;
    gpp_port DUT (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_event, .periph_drive, .periph_drive_en, .port_irq);
    gpp_pad_model pads (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_lvl, .ext_en, .pin_in);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; each phase waits for hready, the latency is never assumed.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'h0};
        hwrite <= w;
        htrans <= gpp_pkg::HTRANS_NONSEQ;
        for (int p = 0; p < 2; p++) begin
            do begin
                @(posedge clk);
            end while (hreadyout !== 1'b1);
            q = hrdata;
            if (p == 0) begin
                htrans <= 2'h0;
                hwdata <= {24'h000000, wd};
            end
        end
    endtask
    task automatic rd(input logic [7:0] idx);
        xfer(1'b0, idx, 8'h00);
    endtask
    function automatic logic [15:0] nxt(input logic [7:0] o, input logic [7:0] v, input logic [7:0] di,
        input logic [7:0] ou);
        case (o)
            8'h00, 8'h20: di = v;
            8'h01: di = di | v;
            8'h02: di = di & ~v;
            8'h03: di = di ^ v;
            8'h04, 8'h21: ou = v;
            8'h05: ou = ou | v;
            8'h06: ou = ou & ~v;
            default: ou = ou ^ v;
        endcase
        return {di, ou};
    endfunction
    function automatic logic [7:0] hit(input logic [2:0] c, input logic rise);
        if (c == gpp_pkg::SENSE_BOTH || c == (rise ? gpp_pkg::SENSE_RISE : gpp_pkg::SENSE_FALL))
            return 8'h10;
        return (!rise && c == gpp_pkg::SENSE_LOW) ? 8'h10 : 8'h00;
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
    initial begin
        seed = 70;
        arst_n = 1'b0;
        hsize = 3'h2;
        {hsel, hwrite, htrans, haddr, hwdata, periph_drive, periph_drive_en, ext_lvl, ext_en, dir, out} = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk(pin_oe, 8'h00);
        rd(8'h09);
        chk(q[7:0], 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd(8'(8'h10 + i));
            chk(q[7:0], 8'h00);
        end
        for (int k = 0; k < 40; k++) begin
            rd(8'h00);
            chk(q[7:0], dir);
            rd(8'h21);
            chk(q[7:0], out);
            chk(pin_oe, dir);
            chk(pin_out, out);
            op = 8'($unsigned($random(seed)) % 12);
            if (op > 8'h08)
                op = op + 8'h17;
            d = 8'($random(seed));
            xfer(1'b1, op, d);
            {dir, out} = nxt(op, d, dir, out);
        end
        $display("register test done");
        xfer(1'b1, 8'h00, 8'h0F);
        dir = 8'h0F;
        ext_en <= 8'hF0;
        ext_lvl <= d;
        xfer(1'b1, 8'h11, 8'h80);
        repeat (4) @(posedge clk);
        rd(8'h08);
        chk(q[7:0] & 8'hFD, {d[7:4], out[3:0]} & 8'hFD);
        chk(q[7:0] & 8'h02, out & 8'h02);
        chk(pin_out & 8'h02, ~out & 8'h02);
        $display("input and polarity test done");
        for (int c = 0; c < 6; c++) begin
            ext_lvl <= 8'h10;
            xfer(1'b1, 8'h14, 8'(c));
            repeat (4) @(posedge clk);
            f = 8'h00;
            for (int e = 0; e < 2; e++) begin
                ext_lvl <= {3'h0, e[0], 4'h0};
                f = f | hit(3'(c), e[0]);
                repeat (8) @(posedge clk);
                rd(8'h09);
                chk(q[7:0], f);
                chk({7'h00, port_irq}, {7'h00, |f});
                rd(8'h08);
                chk(q[7:0] & 8'h10, (e[0] || c == gpp_pkg::SENSE_OFF) ? 8'h10 : 8'h00);
            end
            chk(pin_event & 8'h10, (c == gpp_pkg::SENSE_OFF) ? 8'h00 : 8'h10);
            xfer(1'b1, 8'h09, 8'h10);
            rd(8'h09);
            chk(q[7:0], 8'h00);
        end
        $display("sense test done");
        xfer(1'b1, 8'h18, 8'h01);
        xfer(1'b1, 8'h15, 8'h08);
        periph_drive <= 8'($random(seed));
        periph_drive_en <= 8'($random(seed));
        repeat (4) @(posedge clk);
        chk(pin_oe, {dir[7:1], periph_drive_en[0]});
        chk(pin_out & 8'h01, periph_drive & 8'h01);
        chk(pin_pullup, 8'h20);
        xfer(1'b1, 8'h01, 8'h20);
        repeat (4) @(posedge clk);
        chk(pin_pullup, 8'h00);
        $display("override test done");
        conclude();
    end
endmodule
